// file: hw/imubf_consts.svh
// Purpose: Offsets, field positions, reset values and counts of the bias/filter block
// Assumes: Byte addresses on the serial register port, 16-bit words on even addresses
// Notes: Definitions only
`ifndef IMUBF_CONSTS_SVH
`define IMUBF_CONSTS_SVH

`define IMUBF_GYRO_X_OFFSET_LOWER 7'h40
`define IMUBF_GYRO_X_OFFSET_UPPER 7'h42
`define IMUBF_GYRO_Y_OFFSET_LOWER 7'h44
`define IMUBF_GYRO_Y_OFFSET_UPPER 7'h46
`define IMUBF_GYRO_Z_OFFSET_LOWER 7'h48
`define IMUBF_GYRO_Z_OFFSET_UPPER 7'h4A
`define IMUBF_ACCEL_X_OFFSET_LOWER 7'h4C
`define IMUBF_ACCEL_X_OFFSET_UPPER 7'h4E
`define IMUBF_ACCEL_Y_OFFSET_LOWER 7'h50
`define IMUBF_ACCEL_Y_OFFSET_UPPER 7'h52
`define IMUBF_ACCEL_Z_OFFSET_LOWER 7'h54
`define IMUBF_ACCEL_Z_OFFSET_UPPER 7'h56
`define IMUBF_OFFSET_LAST_BYTE 7'h57
`define IMUBF_SMOOTHING_FILTER_SIZE 7'h5C
`define IMUBF_OFFSET_RESET 16'h0000
`define IMUBF_FILTER_SIZE_RESET 3'h0
`define IMUBF_SIZE_MSB 2
`define IMUBF_SIZE_LSB 0
`define IMUBF_OFFSET_WORDS 12
`define IMUBF_SIZE_SIXTEEN 3'h4

`endif

// file: hw/imubf_pkg.sv
// Purpose: Types shared by the bias/filter block
// Assumes: Six channels, gyro x/y/z then accel x/y/z
// Notes: Constants live in imubf_consts.svh
package imubf_pkg;
  typedef logic [2:0] imubf_chan_t;
  typedef logic [31:0] imubf_word_t;
  typedef enum logic {IMUBF_IDLE, IMUBF_CALC} imubf_state_t;
endpackage : imubf_pkg

// file: hw/imubf_hist_mem.sv
// Purpose: Sample history store for one averaging stage
// Assumes: One write and one read port, same clock
// Notes: Read data comes out of a register, one cycle after the address
`timescale 1ns/1ps
module imubf_hist_mem #(
  parameter int W = 32,
  parameter int AW = 10
) (
  // Clock
  input wire logic ref_clk,
  // Write port
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read port
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem_reg [2**AW];

  always_ff @(posedge ref_clk)
  begin
    if (wr_en)
    begin
      mem_reg[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    rd_data <= mem_reg[rd_addr];
  end
endmodule : imubf_hist_mem

// file: hw/imubf_avg_stage.sv
// Purpose: Time-shared moving-average stage for six channels
// Assumes: Result stands in the output register until the taker is ready
// Notes: One sample every two cycles; history before fill counts as zero
`timescale 1ns/1ps
module imubf_avg_stage #(
  parameter int W = 32,
  parameter int CH = 6,
  parameter int MAXB = 7
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic clear,
  input wire logic [2:0] size_b,
  // Input stream
  input wire logic in_valid,
  output logic in_ready,
  input wire imubf_pkg::imubf_chan_t in_chan,
  input wire logic [W-1:0] in_data,
  // Output stream
  input wire logic out_ready,
  output logic out_valid,
  output imubf_pkg::imubf_chan_t out_chan,
  output logic [W-1:0] out_data
);
  localparam int SW = W + MAXB;

  imubf_pkg::imubf_state_t state_reg;
  imubf_pkg::imubf_chan_t chan_reg;
  logic [W-1:0] data_reg;
  logic signed [SW-1:0] sum_reg [CH];
  logic [MAXB-1:0] ptr_reg [CH];
  logic [MAXB:0] fill_reg [CH];
  logic [MAXB:0] n_taps;
  logic [W-1:0] old_data;
  logic [W-1:0] hist_q;
  logic signed [SW-1:0] sum_next;
  logic signed [SW-1:0] avg;
  logic accept;

  assign n_taps = {{MAXB{1'b0}}, 1'b1} << size_b;
  assign in_ready = (state_reg == imubf_pkg::IMUBF_IDLE) && (!out_valid || out_ready) && !clear;
  assign accept = in_valid && in_ready;
  // Oldest sample leaves the window only once the window is full
  assign old_data = (fill_reg[chan_reg] >= n_taps) ? hist_q : '0;
  assign sum_next = sum_reg[chan_reg] + SW'($signed(data_reg)) - SW'($signed(old_data));
  assign avg = sum_next >>> size_b;

  imubf_hist_mem #(.W(W), .AW(3 + MAXB)) u_hist (
    .ref_clk(ref_clk),
    .wr_en(state_reg == imubf_pkg::IMUBF_CALC && !clear),
    .wr_addr({chan_reg, ptr_reg[chan_reg]}),
    .wr_data(data_reg),
    .rd_addr({in_chan, ptr_reg[in_chan]}),
    .rd_data(hist_q)
  );

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clear)
    begin
      state_reg <= imubf_pkg::IMUBF_IDLE;
    end
    else
    begin
      case (state_reg)
        imubf_pkg::IMUBF_IDLE: state_reg <= accept ? imubf_pkg::IMUBF_CALC : state_reg;
        imubf_pkg::IMUBF_CALC: state_reg <= imubf_pkg::IMUBF_IDLE;
        default: state_reg <= imubf_pkg::IMUBF_IDLE;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      chan_reg <= '0;
      data_reg <= '0;
    end
    else if (accept)
    begin
      chan_reg <= in_chan;
      data_reg <= in_data;
    end
  end

  // Running sum per channel: add newest, drop the one N samples back
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clear)
    begin
      for (int i = 0; i < CH; i++)
      begin
        sum_reg[i] <= '0;
        ptr_reg[i] <= '0;
        fill_reg[i] <= '0;
      end
    end
    else if (state_reg == imubf_pkg::IMUBF_CALC)
    begin
      sum_reg[chan_reg] <= sum_next;
      ptr_reg[chan_reg] <= (ptr_reg[chan_reg] + 1'b1) & MAXB'(n_taps - 1'b1);
      if (fill_reg[chan_reg] < n_taps)
      begin
        fill_reg[chan_reg] <= fill_reg[chan_reg] + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n || clear)
    begin
      out_valid <= 1'b0;
      out_chan <= '0;
      out_data <= '0;
    end
    else if (state_reg == imubf_pkg::IMUBF_CALC)
    begin
      // Register is empty here: accept needed it empty or being taken
      out_valid <= 1'b1;
      out_chan <= chan_reg;
      out_data <= avg[W-1:0];
    end
    else if (out_ready)
    begin
      out_valid <= 1'b0;
    end
  end

  unity_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (state_reg == imubf_pkg::IMUBF_CALC && size_b == 3'h0 && !clear)
      |=> out_valid && out_data == $past(data_reg))
    else $error("One-tap stage does not pass the sample through");

  sixteen_taps_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (size_b == 3'h4) |-> (n_taps == 8'd16 && ptr_reg[chan_reg] < 7'd16))
    else $error("Size four does not give sixteen taps");
endmodule : imubf_avg_stage

// file: hw/imubf_bias_filter.sv
// Purpose: Per-axis user offset correction followed by a two-stage Bartlett smoothing filter
// Assumes: Register port is driven by the serial decoder on the same clock
// Notes: Samples arrive tagged with a channel: 0..2 gyro x/y/z, 3..5 accel x/y/z
`timescale 1ns/1ps
`include "imubf_consts.svh"

module imubf_bias_filter #(
  parameter int MAXB = 7
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port, byte writes, word reads
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wr_data,
  output logic [15:0] reg_rd_data,
  // Calibrated samples in
  input wire logic smp_in_valid,
  output logic smp_in_ready,
  input wire imubf_pkg::imubf_chan_t smp_in_chan,
  input wire imubf_pkg::imubf_word_t smp_in_data,
  // Filtered samples out
  output logic smp_out_valid,
  input wire logic smp_out_ready,
  output imubf_pkg::imubf_chan_t smp_out_chan,
  output imubf_pkg::imubf_word_t smp_out_data
);
  // Decode of the offset block: hit flag and word index
  function automatic logic [4:0] offs_decode(input logic [6:0] a);
    logic [6:0] rel;
    rel = a - `IMUBF_GYRO_X_OFFSET_LOWER;
    offs_decode = {(a >= `IMUBF_GYRO_X_OFFSET_LOWER) && (a <= `IMUBF_OFFSET_LAST_BYTE),
      rel[4:1]};
  endfunction : offs_decode

  function automatic logic filt_hit(input logic [6:0] a);
    filt_hit = (a[6:1] == `IMUBF_SMOOTHING_FILTER_SIZE >> 1);
  endfunction : filt_hit

  logic [15:0] offs_reg [`IMUBF_OFFSET_WORDS];
  logic [2:0] size_reg;
  logic [4:0] wr_dec;
  logic [4:0] rd_dec;
  logic size_wr;
  logic filt_clear;

  assign wr_dec = offs_decode(reg_addr);
  assign rd_dec = offs_decode({reg_addr[6:1], 1'b0});
  assign size_wr = reg_wr_en && (reg_addr == `IMUBF_SMOOTHING_FILTER_SIZE);
  // New window length invalidates every running sum
  assign filt_clear = size_wr;

  // Offset words: low byte at even address, high byte at odd
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `IMUBF_OFFSET_WORDS; i++)
      begin
        offs_reg[i] <= `IMUBF_OFFSET_RESET;
      end
    end
    else if (reg_wr_en && wr_dec[4])
    begin
      if (reg_addr[0])
      begin
        offs_reg[wr_dec[3:0]][15:8] <= reg_wr_data;
      end
      else
      begin
        offs_reg[wr_dec[3:0]][7:0] <= reg_wr_data;
      end
    end
  end

  // Only the three size bits exist; the odd byte is dropped
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      size_reg <= `IMUBF_FILTER_SIZE_RESET;
    end
    else if (size_wr)
    begin
      size_reg <= reg_wr_data[`IMUBF_SIZE_MSB:`IMUBF_SIZE_LSB];
    end
  end

  // Read word held until the next read; unmapped reads give zero
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      reg_rd_data <= 16'h0000;
    end
    else if (reg_rd_en)
    begin
      if (rd_dec[4])
      begin
        reg_rd_data <= offs_reg[rd_dec[3:0]];
      end
      else if (filt_hit(reg_addr))
      begin
        reg_rd_data <= {13'h0000, size_reg};
      end
      else
      begin
        reg_rd_data <= 16'h0000;
      end
    end
  end

  // Two-entry input buffer; ready comes from a flop so a stall loses nothing
  imubf_pkg::imubf_word_t buf_data [2];
  imubf_pkg::imubf_chan_t buf_chan [2];
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic push;
  logic pop;
  logic s1_in_ready;

  assign push = smp_in_valid && smp_in_ready;
  assign pop = (cnt_reg != 2'h0) && s1_in_ready;
  assign cnt_next = cnt_reg + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cnt_reg <= 2'h0;
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      smp_in_ready <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      wr_ptr_reg <= wr_ptr_reg ^ push;
      rd_ptr_reg <= rd_ptr_reg ^ pop;
      smp_in_ready <= (cnt_next != 2'h2);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (push)
    begin
      buf_data[wr_ptr_reg] <= smp_in_data;
      buf_chan[wr_ptr_reg] <= smp_in_chan;
    end
  end

  // Offset correction: same decode for every axis of both sensors
  imubf_pkg::imubf_chan_t head_chan;
  imubf_pkg::imubf_word_t head_data;
  imubf_pkg::imubf_word_t corr;
  imubf_pkg::imubf_word_t corrected;
  logic [3:0] lo_idx;

  assign head_chan = buf_chan[rd_ptr_reg];
  assign head_data = buf_data[rd_ptr_reg];
  assign lo_idx = {head_chan, 1'b0};
  // Upper word lands on the 16-bit output word; lower extends it
  assign corr = {offs_reg[lo_idx + 4'h1], offs_reg[lo_idx]};
  assign corrected = head_data + corr;

  // Cascade of two averaging stages
  logic s1_out_valid;
  imubf_pkg::imubf_chan_t s1_out_chan;
  imubf_pkg::imubf_word_t s1_out_data;
  logic s2_in_ready;
  logic s2_out_valid;
  imubf_pkg::imubf_chan_t s2_out_chan;
  imubf_pkg::imubf_word_t s2_out_data;
  logic s2_out_ready;

  assign s2_out_ready = !smp_out_valid || smp_out_ready;

  imubf_avg_stage #(.W(32), .CH(6), .MAXB(MAXB)) u_stage1 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(filt_clear),
    .size_b(size_reg),
    .in_valid(cnt_reg != 2'h0),
    .in_ready(s1_in_ready),
    .in_chan(head_chan),
    .in_data(corrected),
    .out_ready(s2_in_ready),
    .out_valid(s1_out_valid),
    .out_chan(s1_out_chan),
    .out_data(s1_out_data)
  );

  imubf_avg_stage #(.W(32), .CH(6), .MAXB(MAXB)) u_stage2 (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clear(filt_clear),
    .size_b(size_reg),
    .in_valid(s1_out_valid),
    .in_ready(s2_in_ready),
    .in_chan(s1_out_chan),
    .in_data(s1_out_data),
    .out_ready(s2_out_ready),
    .out_valid(s2_out_valid),
    .out_chan(s2_out_chan),
    .out_data(s2_out_data)
  );

  // Output holding register; data stand until taken
  always_ff @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      smp_out_valid <= 1'b0;
      smp_out_chan <= '0;
      smp_out_data <= '0;
    end
    else if (s2_out_valid && s2_out_ready)
    begin
      smp_out_valid <= 1'b1;
      smp_out_chan <= s2_out_chan;
      smp_out_data <= s2_out_data;
    end
    else if (smp_out_ready)
    begin
      smp_out_valid <= 1'b0;
    end
  end

  reset_values_a: assert property (@(posedge ref_clk)
    !rst_n ##1 1'b1 |-> (offs_reg[0] == 16'h0000 && offs_reg[11] == 16'h0000))
    else $error("Offset words not zero after reset");

  size_reset_a: assert property (@(posedge ref_clk)
    !rst_n ##1 1'b1 |-> size_reg == 3'h0)
    else $error("Filter size not zero after reset");

  byte_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr_en && wr_dec[4] && reg_addr[0])
      |=> offs_reg[$past(wr_dec[3:0])][15:8] == $past(reg_wr_data))
    else $error("Offset high byte not written");

  size_field_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr_en && reg_addr == 7'h5C) |=> size_reg == $past(reg_wr_data[2:0]))
    else $error("Size field not taken from bits 2:0");

  upper_ignored_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr_en && reg_addr == 7'h5D) |=> $stable(size_reg))
    else $error("Upper byte of size register changed the size");

  size_readback_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd_en && reg_addr[6:1] == 6'h2E) |=> reg_rd_data == {13'h0000, $past(size_reg)})
    else $error("Size register reads back wrong");

  bias_sum_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pop && head_chan == 3'h4)
      |-> corrected == head_data + {offs_reg[9], offs_reg[8]})
    else $error("Accel y offset not added to sample");

  stage_handoff_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (s1_out_valid && !s2_in_ready && !filt_clear)
      |=> s1_out_valid && $stable(s1_out_data))
    else $error("First stage result lost while second stage busy");

  out_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (smp_out_valid && !smp_out_ready) |=> smp_out_valid && $stable(smp_out_data))
    else $error("Output word changed while stalled");

  buffer_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (cnt_reg == 2'h2) |-> !smp_in_ready && !push)
    else $error("Input buffer overflow");

  low_byte_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr_en && wr_dec[4] && !reg_addr[0])
      |=> offs_reg[$past(wr_dec[3:0])][7:0] == $past(reg_wr_data))
    else $error("Offset low byte not written");

  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_rd_en && !rd_dec[4] && reg_addr[6:1] != 6'h2E) |=> reg_rd_data == 16'h0000)
    else $error("Unmapped word does not read as zero");

  read_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !reg_rd_en |=> $stable(reg_rd_data))
    else $error("Read word changed without a read");

  unmapped_write_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (reg_wr_en && !wr_dec[4]) |=> $stable(offs_reg[1]) && $stable(offs_reg[10]))
    else $error("Write outside the offset block changed an offset");

  size_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !size_wr |=> $stable(size_reg))
    else $error("Filter size changed without a write");

  ready_reset_a: assert property (@(posedge ref_clk)
    !rst_n ##1 1'b1 |-> !smp_in_ready && !smp_out_valid && reg_rd_data == 16'h0000)
    else $error("Handshake outputs not idle after reset");

  gyro_x_corr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pop && head_chan == 3'h0) |-> corr == {offs_reg[1], offs_reg[0]})
    else $error("Gyro x offset not built from its two words");

  gyro_y_corr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pop && head_chan == 3'h1) |-> corr == {offs_reg[3], offs_reg[2]})
    else $error("Gyro y offset not built like gyro x");

  accel_x_corr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pop && head_chan == 3'h3) |-> corr == {offs_reg[7], offs_reg[6]})
    else $error("Accel x offset not built from its two words");

  accel_z_corr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pop && head_chan == 3'h5) |-> corr == {offs_reg[11], offs_reg[10]})
    else $error("Accel z offset not built like accel x");

  gyro_upper_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (pop && head_chan == 3'h0 && offs_reg[0] == 16'h0000)
      |-> corrected == {head_data[31:16] + offs_reg[1], head_data[15:0]})
    else $error("Upper gyro word alone does not act as a 16-bit correction");

  clear_flush_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    filt_clear |=> !s1_out_valid && !s2_out_valid)
    else $error("Size write did not flush the averaging stages");

  sixteen_out_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    smp_out_valid && size_reg == `IMUBF_SIZE_SIXTEEN);
  out_stall_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    smp_out_valid && !smp_out_ready && !smp_in_ready);
  size_change_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    filt_clear && cnt_reg != 2'h0);
  gyro_bias_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
    pop && corr != 32'h00000000 && head_chan == 3'h2);
endmodule : imubf_bias_filter

// file: sim/imubf_out_sink.sv
// Purpose: Taker of filtered samples with a selectable stall pattern
// Assumes: mode 0 always ready, 1 random stalls, 2 held off
// Notes: Ready changes only just after a rising edge
`timescale 1ns/1ps
module imubf_out_sink (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Control
  input wire logic [1:0] mode,
  // Handshake
  output logic smp_out_ready
);
  int seed = 32'h6445;

  initial smp_out_ready = 1'b0;

  // Slow mode is ready with odds of one in four each cycle, to back up the input buffer
  always @(posedge ref_clk)
  begin
    if (!rst_n || mode == 2'h2)
      smp_out_ready <= 1'b0;
    else if (mode == 2'h1)
      smp_out_ready <= (($random(seed) & 32'h00000003) == 32'h00000000);
    else
      smp_out_ready <= 1'b1;
  end
endmodule : imubf_out_sink

// file: sim/imubf_bias_filter_tb.sv
// Purpose: Self-checking bench for offset correction and smoothing
// Assumes: Offsets and size change only while the pipe is empty
// Notes: Expected samples are computed at the input handshake
`timescale 1ns/1ps
`include "imubf_consts.svh"
`define CHK(got, exp, msg) \
  begin \
    n_compared++; \
    if ((got) !== (exp)) \
    begin \
      err_count++; \
      $display("BAD %0t %s got %h exp %h", $time, msg, got, exp); \
    end \
  end

module imubf_bias_filter_tb;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr_en = 1'b0;
  logic reg_rd_en = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [7:0] reg_wr_data = 8'h00;
  logic [15:0] reg_rd_data;
  logic smp_in_valid = 1'b0;
  logic smp_in_ready;
  imubf_pkg::imubf_chan_t smp_in_chan = 3'h0;
  imubf_pkg::imubf_word_t smp_in_data = 32'h00000000;
  logic smp_out_valid;
  logic smp_out_ready;
  imubf_pkg::imubf_chan_t smp_out_chan;
  imubf_pkg::imubf_word_t smp_out_data;
  logic [1:0] sink_mode = 2'h0;
  logic saw_full = 1'b0;
  logic [34:0] got_e;
  int err_count = 0;
  int n_compared = 0;
  int seed = 32'h6445;
  int size_b = 0;
  logic [15:0] offs [12] = '{default: 16'h0000};
  int hist [2][6][$];
  longint sums [2][6];
  logic [34:0] exp_q [$];

  imubf_bias_filter #(.MAXB(7)) dut (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data),
    .smp_in_valid(smp_in_valid), .smp_in_ready(smp_in_ready),
    .smp_in_chan(smp_in_chan), .smp_in_data(smp_in_data),
    .smp_out_valid(smp_out_valid), .smp_out_ready(smp_out_ready),
    .smp_out_chan(smp_out_chan), .smp_out_data(smp_out_data)
  );

  imubf_out_sink sink (
    .ref_clk(ref_clk), .rst_n(rst_n), .mode(sink_mode), .smp_out_ready(smp_out_ready)
  );

  always #2.5 ref_clk = ~ref_clk;

  function automatic void clear_model();
    for (int s = 0; s < 2; s++)
      for (int c = 0; c < 6; c++)
      begin
        hist[s][c].delete();
        sums[s][c] = 0;
        for (int k = 0; k < (1 << size_b); k++)
          hist[s][c].push_back(0);
      end
  endfunction : clear_model

  // History before fill counts as zero, so the output ramps up
  function automatic int avg_step(int s, int c, int x);
    sums[s][c] += longint'(x) - longint'(hist[s][c].pop_front());
    hist[s][c].push_back(x);
    return int'(sums[s][c] >>> size_b);
  endfunction : avg_step

  function automatic logic [31:0] model(int c, logic [31:0] d);
    logic [31:0] x;
    x = d + {offs[2 * c + 1], offs[2 * c]};
    return avg_step(1, c, avg_step(0, c, x));
  endfunction : model

  function automatic logic [15:0] exp_rd(logic [6:0] a);
    if (a >= 7'h40 && a <= `IMUBF_OFFSET_LAST_BYTE)
      return offs[(a - 7'h40) >> 1];
    if (a[6:1] == 6'h2E)
      return {13'h0000, 3'(size_b)};
    return 16'h0000;
  endfunction : exp_rd

  task automatic wr8(logic [6:0] a, logic [7:0] d);
    @(posedge ref_clk);
    reg_wr_en <= 1'b1;
    reg_addr <= a;
    reg_wr_data <= d;
    @(posedge ref_clk);
    reg_wr_en <= 1'b0;
    if (a == `IMUBF_SMOOTHING_FILTER_SIZE)
    begin
      size_b = d[2:0];
      clear_model();
    end
    else if (a >= 7'h40 && a <= `IMUBF_OFFSET_LAST_BYTE)
    begin
      if (a[0])
        offs[(a - 7'h40) >> 1][15:8] = d;
      else
        offs[(a - 7'h40) >> 1][7:0] = d;
    end
  endtask : wr8

  task automatic wr16(logic [6:0] a, logic [15:0] w);
    wr8(a, w[7:0]);
    wr8(a + 7'h01, w[15:8]);
  endtask : wr16

  task automatic rd_chk(logic [6:0] a);
    @(posedge ref_clk);
    reg_rd_en <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd_en <= 1'b0;
    @(negedge ref_clk);
    `CHK(reg_rd_data, exp_rd(a), "read")
  endtask : rd_chk

  // Valid stays high across takes, so samples go back to back
  task automatic stream(int n);
    int lim;
    @(posedge ref_clk);
    for (int i = 0; i < n; i++)
    begin
      smp_in_valid <= 1'b1;
      smp_in_chan <= 3'(($random(seed) & 32'h7FFFFFFF) % 6);
      smp_in_data <= $random(seed);
      lim = 0;
      do
      begin
        @(posedge ref_clk);
        lim++;
      end
      while (smp_in_ready !== 1'b1 && lim < 3000);
      `CHK(lim < 3000, 1'b1, "input stuck")
      exp_q.push_back({smp_in_chan, model(smp_in_chan, smp_in_data)});
    end
    smp_in_valid <= 1'b0;
  endtask : stream

  task automatic drain();
    int lim;
    lim = 0;
    while (exp_q.size() != 0 && lim < 5000)
    begin
      @(posedge ref_clk);
      lim++;
    end
    `CHK(exp_q.size(), 0, "samples missing")
  endtask : drain

  always @(posedge ref_clk)
  begin
    if (rst_n && smp_in_valid && smp_in_ready === 1'b0)
      saw_full <= 1'b1;
    if (rst_n && smp_out_valid === 1'b1 && smp_out_ready)
    begin
      got_e = (exp_q.size() != 0) ? exp_q.pop_front() : 35'h7FFFFFFFF;
      `CHK({smp_out_chan, smp_out_data}, got_e, "sample")
    end
  end

  task automatic finish_test();
    if (err_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : finish_test

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    err_count++;
    finish_test();
  end

  initial
  begin
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    clear_model();
    // Reset values, unmapped words read as zero
    for (int a = 8'h40; a < 8'h60; a += 2)
      rd_chk(7'(a));
    for (int i = 0; i < 12; i++)
      wr16(7'(8'h40 + 2 * i), 16'($random(seed)));
    wr8(7'h58, 8'hA5);
    wr8(7'h5D, 8'hFF);
    // Odd addresses read the same word
    for (int a = 8'h40; a < 8'h60; a++)
      rd_chk(7'(a));
    wr16(`IMUBF_GYRO_X_OFFSET_LOWER, 16'h0000);
    wr16(`IMUBF_GYRO_X_OFFSET_UPPER, 16'h0003);
    stream(60);
    drain();
    sink_mode <= 2'h1;
    for (int b = 0; b < 8; b++)
    begin
      wr8(`IMUBF_SMOOTHING_FILTER_SIZE, {5'($random(seed)), 3'(b)});
      rd_chk(`IMUBF_SMOOTHING_FILTER_SIZE);
      stream(200);
      drain();
    end
    // Receiver held off: input must refuse, then lose nothing
    saw_full <= 1'b0;
    sink_mode <= 2'h2;
    fork
      stream(30);
      begin
        repeat (200) @(posedge ref_clk);
        `CHK(saw_full, 1'b1, "no backpressure")
        sink_mode <= 2'h0;
      end
    join
    drain();
    finish_test();
  end
endmodule : imubf_bias_filter_tb
